// [logic/vco_cal_and_temp_adc_ctrl.sv]
// VCO core and band calibration sequencer with temperature ADC control
`include "vco_cal_params.svh"

module vco_cal_and_temp_adc_ctrl
  import vco_cal_pkg::*;
#(
  parameter int SETTLE_CYCLES = 256
)(
  // Clock and reset
  input  wire logic         sys_clk_in,
  input  wire logic         sys_rst_in,
  // Phase detector clock enable and reference status
  input  wire logic         phase_detector_clk_in,
  input  wire logic         ref_valid_in,
  // Register access from the serial port
  input  wire reg_req_t     reg_req_in,
  output logic      [7:0]   reg_rdata_out,
  // Analog side
  input  wire logic [7:0]   band_found_in,
  input  wire logic         band_cmp_in,
  input  wire logic [7:0]   adc_sample_in,
  output vco_setting_t      vco_setting_out,
  output logic              band_select_clk_out,
  output logic              adc_clk_en_out,
  output logic              cal_busy_out,
  output logic              adc_valid_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] autocal_control;
  logic [7:0] band_clock_divider;
  logic [7:0] fine_timeout_low;
  logic [7:0] fine_timeout_high_adc_ctrl;
  logic [7:0] coarse_timeout_readback_sel;
  logic [7:0] cal_test_mode;
  logic [7:0] temp_adc_clock_divider;
  logic [7:0] manual_band_value;
  logic [7:0] manual_core_select;
  logic [7:0] adc_clock_gate;
  logic       lock_trigger;

  function automatic logic is_write(input reg_req_t r, input logic [7:0] a);
    is_write = r.wr && (r.addr == a);
  endfunction

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      autocal_control             <= 8'h40;
      band_clock_divider          <= 8'h01;
      fine_timeout_low            <= 8'h02;
      fine_timeout_high_adc_ctrl  <= 8'h00;
      coarse_timeout_readback_sel <= 8'h02;
      cal_test_mode               <= 8'h00;
      temp_adc_clock_divider      <= 8'h01;
      manual_band_value           <= 8'h00;
      manual_core_select          <= 8'h00;
      adc_clock_gate              <= 8'h00;
    end
    else
    begin
      if (is_write(reg_req_in, `REG_AUTOCAL_CONTROL))
        autocal_control <= reg_req_in.wdata;
      if (is_write(reg_req_in, `REG_BAND_CLOCK_DIVIDER))
        band_clock_divider <= reg_req_in.wdata;
      if (is_write(reg_req_in, `REG_FINE_TIMEOUT_LOW))
        fine_timeout_low <= reg_req_in.wdata;
      if (is_write(reg_req_in, `REG_FINE_HIGH_ADC_CTRL))
        fine_timeout_high_adc_ctrl <= reg_req_in.wdata;
      if (is_write(reg_req_in, `REG_COARSE_READBACK_SEL))
        coarse_timeout_readback_sel <= reg_req_in.wdata;
      if (is_write(reg_req_in, `REG_CAL_TEST_MODE))
        cal_test_mode <= reg_req_in.wdata;
      if (is_write(reg_req_in, `REG_TEMP_ADC_CLK_DIV))
        temp_adc_clock_divider <= reg_req_in.wdata;
      if (is_write(reg_req_in, `REG_MANUAL_BAND_VALUE))
        manual_band_value <= reg_req_in.wdata;
      if (is_write(reg_req_in, `REG_MANUAL_CORE_SELECT))
        manual_core_select <= reg_req_in.wdata;
      if (is_write(reg_req_in, `REG_ADC_CLOCK_GATE))
        adc_clock_gate <= reg_req_in.wdata;
    end
  end

  assign lock_trigger = is_write(reg_req_in, `REG_N_INT_LOW);

  ////////////////////////////////////////////////////////////////////////////
  // Decoded fields
  logic        auto_cal_on;
  logic [2:0]  cal_override_mode;
  logic        forced_core;
  logic [4:0]  coarse_settle_count;
  logic [9:0]  fine_count;
  logic [2:0]  readback_source_sel;
  logic        adc_enable;
  logic        adc_start;
  logic        adc_clk_off;
  logic        manual_mode;
  logic [15:0] timeout_total;

  assign auto_cal_on         = autocal_control[`BIT_AUTO_CAL_ON];
  assign cal_override_mode   = cal_test_mode[7:5];
  assign manual_mode         = (cal_override_mode == `OVERRIDE_MANUAL);
  assign forced_core         = (manual_core_select[7:4] != 4'h0);
  assign coarse_settle_count = coarse_timeout_readback_sel[4:0];
  assign fine_count          = {fine_timeout_high_adc_ctrl[1:0], fine_timeout_low};
  assign readback_source_sel = coarse_timeout_readback_sel[7:5];
  assign adc_enable          = fine_timeout_high_adc_ctrl[`BIT_ADC_ENABLE];
  assign adc_start           = fine_timeout_high_adc_ctrl[`BIT_ADC_START];
  assign adc_clk_off         = adc_clock_gate[`BIT_ADC_CLK_OFF];
  assign timeout_total       = 16'({coarse_settle_count, 10'h000}) + 16'(fine_count);

  ////////////////////////////////////////////////////////////////////////////
  // Band select clock divider
  logic [7:0] bsc_count;
  logic       bsc_tick;

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      bsc_count <= 8'h00;
    else if (phase_detector_clk_in)
    begin
      if (bsc_count + 8'h01 >= band_clock_divider)
        bsc_count <= 8'h00;
      else
        bsc_count <= bsc_count + 8'h01;
    end
  end

  assign bsc_tick = phase_detector_clk_in && (bsc_count + 8'h01 >= band_clock_divider);

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      band_select_clk_out <= 1'b0;
    else
      band_select_clk_out <= bsc_tick;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calibration sequencer
  cal_state_t   state;
  logic [15:0]  phase_count;
  logic [3:0]   step_count;
  logic [4:0]   step_cycles;
  logic [7:0]   cal_band;
  logic         cal_core;

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      state       <= CAL_IDLE;
      phase_count <= 16'h0000;
      step_count  <= 4'h0;
      step_cycles <= 5'h00;
    end
    else
    begin
      case (state)
        CAL_IDLE:
        begin
          phase_count <= 16'h0000;
          if (lock_trigger && auto_cal_on && !manual_mode)
            state <= CAL_TIMEOUT;
          else if (lock_trigger)
            state <= CAL_SETTLE;
        end
        CAL_TIMEOUT:
        begin
          if (phase_detector_clk_in)
          begin
            if (phase_count + 16'h0001 >= timeout_total)
            begin
              phase_count <= 16'h0000;
              step_count  <= 4'h0;
              step_cycles <= 5'h00;
              state       <= CAL_BAND;
            end
            else
              phase_count <= phase_count + 16'h0001;
          end
        end
        CAL_BAND:
        begin
          if (bsc_tick)
          begin
            if (step_cycles == `CYCLES_PER_STEP - 5'h01)
            begin
              step_cycles <= 5'h00;
              if (step_count == `BAND_STEPS - 4'h1)
                state <= CAL_SETTLE;
              else
                step_count <= step_count + 4'h1;
            end
            else
              step_cycles <= step_cycles + 5'h01;
          end
        end
        CAL_SETTLE:
        begin
          if (phase_detector_clk_in)
          begin
            if (phase_count + 16'h0001 >= 16'(SETTLE_CYCLES))
            begin
              phase_count <= 16'h0000;
              state       <= CAL_IDLE;
            end
            else
              phase_count <= phase_count + 16'h0001;
          end
        end
        default:
          state <= CAL_IDLE;
      endcase
    end
  end

  // Band result latched at each step end so readback is stable afterwards
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      cal_band <= 8'h00;
      cal_core <= 1'b0;
    end
    else if (state == CAL_BAND && bsc_tick && step_cycles == `CYCLES_PER_STEP - 5'h01)
    begin
      cal_band <= band_found_in;
      cal_core <= band_cmp_in | cal_core | 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      vco_setting_out <= '0;
    else if (lock_trigger && manual_mode)
    begin
      vco_setting_out.core_on <= forced_core;
      vco_setting_out.band    <= manual_band_value;
    end
    else if (state == CAL_BAND && !manual_mode)
    begin
      vco_setting_out.core_on <= cal_core;
      vco_setting_out.band    <= cal_band;
    end
  end

  assign cal_busy_out = (state != CAL_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Temperature ADC
  logic [9:0] adc_div_limit;
  logic [9:0] adc_div_count;
  logic       adc_tick;
  logic [4:0] adc_cycles;
  logic [7:0] adc_result;

  // divide by four times divider plus two
  assign adc_div_limit = 10'(temp_adc_clock_divider) * `ADC_DIV_MULT + `ADC_DIV_ADD;

  // clock runs only with valid reference
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in || !adc_enable || adc_clk_off)
      adc_div_count <= 10'h000;
    else if (phase_detector_clk_in && ref_valid_in)
    begin
      if (adc_div_count + 10'h001 >= adc_div_limit)
        adc_div_count <= 10'h000;
      else
        adc_div_count <= adc_div_count + 10'h001;
    end
  end

  assign adc_tick = adc_enable && !adc_clk_off && phase_detector_clk_in && ref_valid_in
                    && (adc_div_count + 10'h001 >= adc_div_limit);
  assign adc_clk_en_out = adc_tick;

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in || !adc_start || !adc_enable)
    begin
      adc_cycles    <= 5'h00;
      adc_valid_out <= 1'b0;
    end
    else if (adc_tick && !adc_valid_out)
    begin
      if (adc_cycles == `ADC_CONV_CYCLES - 5'h01)
        adc_valid_out <= 1'b1;
      else
        adc_cycles <= adc_cycles + 5'h01;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      adc_result <= 8'h00;
    else if (adc_tick && adc_start && !adc_valid_out
             && adc_cycles == `ADC_CONV_CYCLES - 5'h01)
      adc_result <= adc_sample_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register readback
  logic [7:0] next_rdata;

  always_comb
  begin
    next_rdata = 8'h00;
    case (reg_req_in.addr)
      `REG_AUTOCAL_CONTROL:      next_rdata = autocal_control;
      `REG_BAND_CLOCK_DIVIDER:   next_rdata = band_clock_divider;
      `REG_FINE_TIMEOUT_LOW:     next_rdata = fine_timeout_low;
      `REG_FINE_HIGH_ADC_CTRL:   next_rdata = fine_timeout_high_adc_ctrl;
      `REG_COARSE_READBACK_SEL:  next_rdata = coarse_timeout_readback_sel;
      `REG_CAL_TEST_MODE:        next_rdata = cal_test_mode;
      `REG_TEMP_ADC_CLK_DIV:     next_rdata = temp_adc_clock_divider;
      `REG_MANUAL_BAND_VALUE:    next_rdata = manual_band_value;
      `REG_MANUAL_CORE_SELECT:   next_rdata = manual_core_select;
      `REG_ADC_CLOCK_GATE:       next_rdata = adc_clock_gate;
      `REG_CAL_DATA_READBACK:
      begin
        if (readback_source_sel == `READBACK_SEL_TEMP)
          next_rdata = adc_result;
        else if (readback_source_sel == `READBACK_SEL_BAND)
          next_rdata = {3'h0, vco_setting_out.band[4:0]};
      end
      `REG_CAL_DATA_READBACK_HI:
      begin
        if (readback_source_sel == `READBACK_SEL_BAND)
          next_rdata = {7'h00, vco_setting_out.core_on};
      end
      default:                   next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      reg_rdata_out <= 8'h00;
    else if (reg_req_in.rd)
      reg_rdata_out <= next_rdata;
  end

endmodule

// [logic/vco_cal_params.svh]
// Register offsets, field positions and timing constants for the VCO calibration block
`ifndef VCO_CAL_PARAMS_SVH
`define VCO_CAL_PARAMS_SVH

`define REG_AUTOCAL_CONTROL      8'h12
`define REG_N_INT_LOW            8'h10
`define REG_BAND_CLOCK_DIVIDER   8'h30
`define REG_FINE_TIMEOUT_LOW     8'h31
`define REG_FINE_HIGH_ADC_CTRL   8'h32
`define REG_COARSE_READBACK_SEL  8'h33
`define REG_CAL_TEST_MODE        8'h34
`define REG_TEMP_ADC_CLK_DIV     8'h35
`define REG_MANUAL_BAND_VALUE    8'h37
`define REG_MANUAL_CORE_SELECT   8'h38
`define REG_CAL_DATA_READBACK    8'h6E
`define REG_CAL_DATA_READBACK_HI 8'h6F
`define REG_ADC_CLOCK_GATE       8'h73

`define BIT_AUTO_CAL_ON          6
`define BIT_ADC_ENABLE           2
`define BIT_ADC_START            3
`define BIT_ADC_CLK_OFF          2

`define OVERRIDE_MANUAL          3'h2
`define READBACK_SEL_BAND        3'h1
`define READBACK_SEL_TEMP        3'h5

`define COARSE_UNIT              16'h0400
`define BAND_STEPS               4'hB
`define CYCLES_PER_STEP          5'h10
`define ADC_CONV_CYCLES          5'h10
`define ADC_DIV_MULT             10'h004
`define ADC_DIV_ADD              10'h002
`define SETTLE_PFD_CYCLES        16'h0100

`endif

// [logic/vco_cal_pkg.sv]
// Types shared by the VCO calibration and temperature ADC control block
package vco_cal_pkg;

  typedef enum logic [2:0] {
    CAL_IDLE,
    CAL_TIMEOUT,
    CAL_BAND,
    CAL_SETTLE
  } cal_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       core_on;
    logic [7:0] band;
  } vco_setting_t;

endpackage

// [bench/vco_cal_checker.sv]
// Port-level assertions for the VCO calibration and temperature ADC block
module vco_cal_checker
  import vco_cal_pkg::*;
(
  // Clock and reset
  input wire logic         sys_clk_in,
  input wire logic         sys_rst_in,
  // Inputs watched
  input wire logic         phase_detector_clk_in,
  input wire logic         ref_valid_in,
  input wire reg_req_t     reg_req_in,
  // Outputs watched
  input wire logic [7:0]   reg_rdata_out,
  input wire vco_setting_t vco_setting_out,
  input wire logic         band_select_clk_out,
  input wire logic         adc_clk_en_out,
  input wire logic         cal_busy_out,
  input wire logic         adc_valid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  logic [2:0] sel;
  logic [2:0] mode;
  logic [7:0] band;
  logic       core_set;
  logic       gate;
  logic       trig;
  logic       rd_rb;
  assign trig  = reg_req_in.wr && reg_req_in.addr == 8'h10;
  assign rd_rb = reg_req_in.rd && reg_req_in.addr[7:1] == 7'h37;
  // Shadows of host-written fields, needed to predict the forced setting, the readback source and the ADC clock gate
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      sel      <= 3'h0;
      mode     <= 3'h0;
      band     <= 8'h00;
      core_set <= 1'b0;
      gate     <= 1'b0;
    end
    else if (reg_req_in.wr)
    begin
      if (reg_req_in.addr == 8'h33) sel <= reg_req_in.wdata[7:5];
      if (reg_req_in.addr == 8'h34) mode <= reg_req_in.wdata[7:5];
      if (reg_req_in.addr == 8'h37) band <= reg_req_in.wdata;
      if (reg_req_in.addr == 8'h38) core_set <= reg_req_in.wdata[7:4] != 4'h0;
      if (reg_req_in.addr == 8'h73) gate <= reg_req_in.wdata[2];
    end
  end
  a_busy_on_trig: assert property (trig |=> cal_busy_out)
    else $error("lock trigger did not start the sequencer");
  a_manual_apply: assert property (trig && mode == 3'h2 |=>
    vco_setting_out == {core_set, band})
    else $error("forced core and band not applied");
  a_setting_hold: assert property ($changed(vco_setting_out) |-> cal_busy_out)
    else $error("setting changed while idle");
  a_adc_clear: assert property (reg_req_in.wr && reg_req_in.addr == 8'h32 &&
    !(reg_req_in.wdata[2] && reg_req_in.wdata[3]) |=> ##1 !adc_valid_out)
    else $error("result valid after enable or start cleared");
  a_valid_tick: assert property ($rose(adc_valid_out) |-> $past(adc_clk_en_out))
    else $error("result valid without an ADC clock tick");
  a_tick_ref: assert property (adc_clk_en_out |->
    ref_valid_in && phase_detector_clk_in && !gate)
    else $error("ADC tick without reference, PFD pulse or with gate");
  a_rb_band: assert property (rd_rb && !reg_req_in.addr[0] && sel == 3'h1 |=>
    reg_rdata_out[4:0] == $past(vco_setting_out.band[4:0]))
    else $error("band readback differs from band in use");
  a_rb_gated: assert property (rd_rb && sel != 3'h1 && sel != 3'h5 |=>
    reg_rdata_out == 8'h00)
    else $error("readback not zero for unused selector");
  a_bsc_on_pfd: assert property (band_select_clk_out |-> $past(phase_detector_clk_in))
    else $error("band clock pulse without a PFD pulse");
endmodule
bind vco_cal_and_temp_adc_ctrl vco_cal_checker i_chk (.sys_clk_in, .sys_rst_in,
  .phase_detector_clk_in, .ref_valid_in, .reg_req_in, .reg_rdata_out, .vco_setting_out,
  .band_select_clk_out, .adc_clk_en_out, .cal_busy_out, .adc_valid_out);

// [bench/ana_side_model.sv]
// Behavioural model of the analog side: PFD pulses, reference status, search and ADC data
module ana_side_model (
  // Clock, reset and control
  input  wire logic  clk_in,
  input  wire logic  rst_in,
  input  wire logic  ref_on_in,
  // Analog side
  output logic       pfd_out,
  output logic       ref_valid_out,
  output logic       band_cmp_out,
  output logic [7:0] band_out,
  output logic [7:0] adc_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // PFD at half the system rate so that pulses never touch
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pfd_out      <= 1'b0;
      band_cmp_out <= 1'b0;
    end
    else
    begin
      pfd_out      <= ~pfd_out;
      band_cmp_out <= band_cmp_out ^ pfd_out;
    end
  end
  assign ref_valid_out = ref_on_in;
  assign band_out      = 8'h13;
  assign adc_out       = 8'hA5;
endmodule

// [bench/tb.sv]
// Self-checking testbench for the VCO calibration and temperature ADC block
module tb
  import vco_cal_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         sys_clk_in = 1'b0;
  logic         sys_rst_in = 1'b1;
  logic         ref_on     = 1'b1;
  reg_req_t     req        = '0;
  logic [7:0]   rdata;
  logic [7:0]   band_found;
  logic [7:0]   adc_sample;
  logic         pfd;
  logic         ref_valid;
  logic         band_cmp;
  logic         busy;
  logic         valid;
  logic         adc_en;
  vco_setting_t vco;
  int           mismatches = 0;
  int           n_compared = 0;
  int           cyc        = 0;
  int           p;
  int           t;
  logic [7:0]   ra [10] = '{8'h12, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h37, 8'h38, 8'h73};
  logic [7:0]   rv [10] = '{8'h40, 8'h01, 8'h02, 8'h00, 8'h02, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};

  always #5 sys_clk_in = ~sys_clk_in;

  ana_side_model i_ana (.clk_in(sys_clk_in), .rst_in(sys_rst_in), .ref_on_in(ref_on),
    .pfd_out(pfd), .ref_valid_out(ref_valid), .band_cmp_out(band_cmp),
    .band_out(band_found), .adc_out(adc_sample));

  vco_cal_and_temp_adc_ctrl #(.SETTLE_CYCLES(4)) i_dut (.sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in), .phase_detector_clk_in(pfd), .ref_valid_in(ref_valid),
    .reg_req_in(req), .reg_rdata_out(rdata), .band_found_in(band_found),
    .band_cmp_in(band_cmp), .adc_sample_in(adc_sample), .vco_setting_out(vco),
    .band_select_clk_out(), .adc_clk_en_out(adc_en), .cal_busy_out(busy),
    .adc_valid_out(valid));

  ////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int exp, input int tol);
    n_compared++;
    if (got < exp - tol || got > exp + tol)
    begin
      mismatches++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.wr    = 1'b1;
    req.addr  = a;
    req.wdata = d;
    @(posedge sys_clk_in);
    #1 req.wr = 1'b0;
    @(posedge sys_clk_in);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req.rd   = 1'b1;
    req.addr = a;
    @(posedge sys_clk_in);
    #1 req.rd = 1'b0;
    chk(rdata, exp);
    @(posedge sys_clk_in);
    #1;
  endtask

  // Counts PFD pulses and ADC ticks seen between edges
  task automatic step();
    @(posedge sys_clk_in);
    #1;
    if (pfd) p++;
    if (adc_en) t++;
  endtask

  task automatic run_cal();
    p = 0;
    wr(8'h10, 8'h00);
    while (busy === 1'b1 && p < 9000) step();
  endtask

  task automatic conv(input int lim);
    p = 0;
    t = 0;
    repeat (lim) if (valid !== 1'b1) step();
  endtask

  ////////////////////////////////////////////////////////////
  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (16) @(posedge sys_clk_in);
    #1 sys_rst_in = 1'b0;
    foreach (ra[i]) rd(ra[i], rv[i]);
    rd(8'h6E, 8'h00);
    rd(8'h50, 8'h00);
    wr(8'h35, 8'hC3);
    rd(8'h35, 8'hC3);
    $display("test registers done");
    wr(8'h30, 8'h03);
    wr(8'h31, 8'h05);
    wr(8'h32, 8'h01);
    wr(8'h33, 8'h02);
    run_cal();
    // Bench misses the pulse after the trigger; band clock phase costs about one more
    chk_rng(p, 2 * 1024 + 261 + 11 * 16 * 3 + 4 - 2, 2);
    wr(8'h33, 8'h22);
    rd(8'h6E, 8'h13);
    rd(8'h6F, 8'h01);
    wr(8'h12, 8'h00);
    run_cal();
    chk_rng(p, 4, 2);
    $display("test autocal done");
    wr(8'h34, 8'h40);
    wr(8'h37, 8'h9C);
    wr(8'h38, 8'h10);
    run_cal();
    chk(vco, 9'h19C);
    rd(8'h6E, 8'h1C);
    wr(8'h38, 8'h00);
    run_cal();
    chk(vco, 9'h09C);
    $display("test manual done");
    wr(8'h35, 8'h02);
    wr(8'h32, 8'h04);
    wr(8'h32, 8'h0C);
    conv(3000);
    chk_rng(t, 16, 1);
    chk_rng(p, 16 * (4 * 2 + 2), 10);
    wr(8'h33, 8'hA2);
    rd(8'h6E, 8'hA5);
    chk(rdata - 8'h73, 8'h32);
    wr(8'h32, 8'h00);
    chk(valid, 1'b0);
    for (int i = 0; i < 2; i++)
    begin
      ref_on = i[0];
      wr(8'h73, {5'h00, i[0], 2'h0});
      wr(8'h32, 8'h04);
      wr(8'h32, 8'h0C);
      conv(400);
      chk(valid, 1'b0);
      ref_on = 1'b1;
      wr(8'h73, 8'h00);
      conv(3000);
      chk(valid, 1'b1);
      wr(8'h32, 8'h00);
    end
    $display("test adc done");
    report_and_stop();
  end
endmodule
